// ==== tb/hpc_board_model.sv ====
// board-side model of the supply indicator, over-current sense and strap pins
`timescale 1ns/10ps
module hpc_board_model (
    // clock
    input wire logic ref_clk_i,
    // requests from the bench
    input wire logic supply_req_i,
    input wire logic oc_req_i,
    input wire logic [1:0] straps_req_i,
    // pins towards the hub
    output logic local_supply_present_o = 1'b0,
    output logic overcurrent_n_o = 1'b1,
    output logic [1:0] fixed_port_straps_o = 2'h0
);
    // pins move just after the rising edge, like a real slow board signal
    always @(posedge ref_clk_i)
    begin
        local_supply_present_o <= supply_req_i;
        overcurrent_n_o <= ~oc_req_i;
        fixed_port_straps_o <= straps_req_i;
    end
endmodule : hpc_board_model

// ==== tb/hpc_config_bank_tb.sv ====
// self-checking bench for the hub configuration bank
`timescale 1ns/10ps
module hpc_config_bank_tb;
    localparam int CNT [4] = '{5, 10, 20, 40};
    logic ref_clk_i, arst_n_i, cfg_wr_i, cfg_rd_i, cfg_from_straps_i, static_self_powered_i;
    logic [7:0] cfg_addr_i, cfg_wdata_i, cfg_rdata_o;
    logic local_supply_present_i, overcurrent_n_i, supply_req, oc_req;
    logic [1:0] fixed_port_straps_i, straps_req;
    logic upstream_attach_o, downstream_power_en_o, self_powered_o, overcurrent_fault_o;
    logic [7:0] ofs [3] = '{8'h07, 8'h08, 8'h09};
    logic [7:0] msk [3] = '{8'hB8, 8'h09, 8'h1E};
    logic [3:0] smap [4] = '{4'h0, 4'h1, 4'h3, 4'h7};
    hpc_pkg::hpc_cfg_t cfg_o;
    int num_errors = 0;
    int tests_run = 0;

    hpc_config_bank #(.OC_CNT0(5), .OC_CNT1(10), .OC_CNT2(20), .OC_CNT3(40))
    hpc_config_bank_inst (
        .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .cfg_wr_i(cfg_wr_i),
        .cfg_rd_i(cfg_rd_i), .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i),
        .cfg_rdata_o(cfg_rdata_o), .cfg_from_straps_i(cfg_from_straps_i),
        .static_self_powered_i(static_self_powered_i),
        .local_supply_present_i(local_supply_present_i),
        .fixed_port_straps_i(fixed_port_straps_i), .overcurrent_n_i(overcurrent_n_i),
        .upstream_attach_o(upstream_attach_o), .downstream_power_en_o(downstream_power_en_o),
        .self_powered_o(self_powered_o), .overcurrent_fault_o(overcurrent_fault_o),
        .cfg_o(cfg_o));

    hpc_board_model hpc_board_model_inst (
        .ref_clk_i(ref_clk_i), .supply_req_i(supply_req), .oc_req_i(oc_req),
        .straps_req_i(straps_req), .local_supply_present_o(local_supply_present_i),
        .overcurrent_n_o(overcurrent_n_i), .fixed_port_straps_o(fixed_port_straps_i));

    // ------------------------------------------------------------
    // compare and access tasks
    // ------------------------------------------------------------
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: got 0x%h expected 0x%h", $time, got, exp);
        end
    endtask : chk_byte

    task automatic chk_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: got 0x%h expected 0x%h", $time, got, exp);
        end
    endtask : chk_bit

    task automatic chk_cfg(input hpc_pkg::hpc_cfg_t got, input hpc_pkg::hpc_cfg_t exp);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: got 0x%h expected 0x%h", $time, got, exp);
        end
    endtask : chk_cfg

    task automatic cycles(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask : cycles

    // strobes are one cycle wide and always dropped before the next access
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        cfg_wr_i = 1'b1;
        cfg_addr_i = a;
        cfg_wdata_i = d;
        cycles(1);
        cfg_wr_i = 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        cfg_rd_i = 1'b1;
        cfg_addr_i = a;
        cycles(1);
        cfg_rd_i = 1'b0;
        chk_byte(cfg_rdata_o, exp);
    endtask : rd_reg

    // one supply change with dynamic switching on: drop, quiet time, re-attach
    task automatic power_step(input logic lvl);
        supply_req = lvl;
        static_self_powered_i = ~lvl;
        cycles(6);
        chk_bit(upstream_attach_o, 1'b0);
        chk_bit(downstream_power_en_o, 1'b0);
        cycles(990);
        chk_bit(upstream_attach_o, 1'b0);
        cycles(14);
        chk_bit(upstream_attach_o, 1'b1);
        chk_bit(downstream_power_en_o, 1'b1);
        chk_bit(self_powered_o, lvl);
    endtask : power_step

    task automatic results;
        $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : results

    // ------------------------------------------------------------
    // clock, watchdog and test sequence
    // ------------------------------------------------------------
    initial
    begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    // the sequence needs about 2230 cycles
    initial
    begin
        repeat (20000) @(posedge ref_clk_i);
        num_errors++;
        $display("watchdog expired at %0t", $time);
        results();
    end

    initial
    begin
        arst_n_i = 1'b0;
        cfg_wr_i = 1'b0;
        cfg_rd_i = 1'b0;
        cfg_addr_i = 8'h00;
        cfg_wdata_i = 8'h00;
        cfg_from_straps_i = 1'b0;
        static_self_powered_i = 1'b1;
        supply_req = 1'b0;
        oc_req = 1'b0;
        straps_req = 2'h0;
        cycles(4);
        arst_n_i = 1'b1;
        cycles(3);
        for (int i = 0; i < 3; i++)
            rd_reg(ofs[i], 8'h00);
        chk_bit(upstream_attach_o, 1'b1);
        chk_bit(overcurrent_fault_o, 1'b0);
        $display("test reset done");

        for (int i = 0; i < 3; i++)
        begin
            wr_reg(ofs[i], 8'hFF);
            rd_reg(ofs[i], msk[i]);
            wr_reg(ofs[i], 8'h00);
            rd_reg(ofs[i], 8'h00);
        end
        wr_reg(8'h0A, 8'hFF);
        rd_reg(8'h0A, 8'h00);
        rd_reg(8'h09, 8'h00);
        $display("test register access done");

        supply_req = 1'b1;
        cycles(12);
        chk_bit(upstream_attach_o, 1'b1);
        chk_bit(downstream_power_en_o, 1'b1);
        chk_bit(self_powered_o, 1'b1);
        // with dynamic switching off the static bit alone decides
        static_self_powered_i = 1'b0;
        cycles(1);
        chk_bit(self_powered_o, 1'b0);
        $display("test static power done");

        wr_reg(8'h07, 8'h38);
        wr_reg(8'h08, 8'h08);
        wr_reg(8'h09, 8'h14);
        chk_cfg(cfg_o, {1'b0, 2'h3, 1'b1, 1'b1, 1'b0, 4'hA});
        wr_reg(8'h07, 8'hA0);
        wr_reg(8'h08, 8'h01);
        wr_reg(8'h09, 8'h02);
        chk_cfg(cfg_o, {1'b1, 2'h2, 1'b0, 1'b0, 1'b1, 4'h1});
        static_self_powered_i = 1'b0;
        cycles(2);
        chk_bit(self_powered_o, 1'b1);
        chk_bit(upstream_attach_o, 1'b1);
        $display("test field outputs done");

        power_step(1'b0);
        power_step(1'b1);
        $display("test dynamic power done");

        for (int i = 0; i < 4; i++)
        begin
            wr_reg(8'h07, 8'(i << 4));
            oc_req = 1'b1;
            cycles(CNT[i]);
            chk_bit(overcurrent_fault_o, 1'b0);
            cycles(8);
            chk_bit(overcurrent_fault_o, 1'b1);
            oc_req = 1'b0;
            cycles(5);
            chk_bit(overcurrent_fault_o, 1'b0);
        end
        $display("test over-current delay done");

        // the delay field keeps the last value of the loop above
        wr_reg(8'h08, 8'h00);
        wr_reg(8'h09, 8'h1E);
        cfg_from_straps_i = 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            straps_req = 2'(k);
            cycles(5);
            chk_cfg(cfg_o, {1'b0, 2'h3, |smap[k], 1'b0, 1'b0, smap[k]});
        end
        rd_reg(8'h09, 8'h1E);
        $display("test strap configuration done");

        // reset in mid-run: registers clear, straps are seen again after the synchroniser
        arst_n_i = 1'b0;
        cycles(2);
        arst_n_i = 1'b1;
        cycles(3);
        rd_reg(8'h07, 8'h00);
        rd_reg(8'h09, 8'h00);
        chk_cfg(cfg_o, {1'b0, 2'h0, 1'b1, 1'b0, 1'b0, 4'h7});
        chk_bit(upstream_attach_o, 1'b1);
        $display("test reset recovery done");
        results();
    end
endmodule : hpc_config_bank_tb

// ==== verilog/hpc_config_bank.sv ====
// configuration bank and dynamic power switching control for the hub
//
// Summary of operation
// - with the dynamic bit set the hub moves between self and bus power on its own, else never.
// - in dynamic mode the local supply indicator is watched on every cycle.
// - in dynamic mode a change of local supply at once drops upstream attach and all downstream power.
// - after the drop the hub re-attaches as self-powered with supply present, else bus-powered.
// - the two-bit delay field picks 0.1, 4, 8 or 16 ms of over-current qualification.
// - the compound bit makes the hub report a compound device; software must also fix ports.
// - in strap configuration any fixed port makes the hub report a compound device.
// - the remap bit selects standard port numbering at 0 and mapping mode at 1.
// - the string bit enables string descriptor support.
// - bits 1 to 4 of the fixed-port byte mark ports 1 to 4 as non-removable.
// - in strap configuration the two fixed-port straps choose the fixed ports.
// - in dynamic mode the static self/bus bit is ignored in favour of the supply indicator.
`timescale 1ns/10ps
module hpc_config_bank #(
    parameter int OC_CNT0 = hpc_pkg::OC_DLY0_CYC,
    parameter int OC_CNT1 = hpc_pkg::OC_DLY1_CYC,
    parameter int OC_CNT2 = hpc_pkg::OC_DLY2_CYC,
    parameter int OC_CNT3 = hpc_pkg::OC_DLY3_CYC
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    // configuration load port
    input wire logic cfg_wr_i,
    input wire logic cfg_rd_i,
    input wire logic [7:0] cfg_addr_i,
    input wire logic [7:0] cfg_wdata_i,
    output logic [7:0] cfg_rdata_o,
    // configuration source and static power bit
    input wire logic cfg_from_straps_i,
    input wire logic static_self_powered_i,
    // pins
    input wire logic local_supply_present_i,
    input wire logic [1:0] fixed_port_straps_i,
    input wire logic overcurrent_n_i,
    // hub control
    output logic upstream_attach_o,
    output logic downstream_power_en_o,
    output logic self_powered_o,
    output logic overcurrent_fault_o,
    output hpc_pkg::hpc_cfg_t cfg_o
);

    // ------------------------------------------------------------
    // function
    // ------------------------------------------------------------
    // straps give a count of fixed ports starting at port 1
    function automatic logic [3:0] strap_ports(input logic [1:0] s);
        unique case (s)
            2'h0: strap_ports = 4'h0;
            2'h1: strap_ports = 4'h1;
            2'h2: strap_ports = 4'h3;
            2'h3: strap_ports = 4'h7;
        endcase
    endfunction : strap_ports

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic supply_s;
    logic oc_s;
    logic [1:0] straps_s;

    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
        end
        else
        begin
            sync1_reg <= {fixed_port_straps_i, !overcurrent_n_i, local_supply_present_i};
            sync2_reg <= sync1_reg;
        end
    end

    assign supply_s = sync2_reg[0];
    assign oc_s = sync2_reg[1];
    assign straps_s = sync2_reg[3:2];

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] pwr_cfg_reg;
    logic [7:0] pwr_cfg_next;
    logic [7:0] port_cfg_reg;
    logic [7:0] port_cfg_next;
    logic [7:0] fixed_reg;
    logic [7:0] fixed_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    always_comb
    begin
        pwr_cfg_next = pwr_cfg_reg;
        port_cfg_next = port_cfg_reg;
        fixed_next = fixed_reg;
        rdata_next = rdata_reg;
        if (cfg_wr_i)
        begin
            // reserved bits never reach the flops
            unique case (cfg_addr_i)
                hpc_pkg::PWR_CFG_OFS: pwr_cfg_next = cfg_wdata_i & hpc_pkg::PWR_CFG_MASK;
                hpc_pkg::PORT_CFG_OFS: port_cfg_next = cfg_wdata_i & hpc_pkg::PORT_CFG_MASK;
                hpc_pkg::FIXED_OFS: fixed_next = cfg_wdata_i & hpc_pkg::FIXED_MASK;
                default: ;
            endcase
        end
        if (cfg_rd_i)
        begin
            unique case (cfg_addr_i)
                hpc_pkg::PWR_CFG_OFS: rdata_next = pwr_cfg_reg;
                hpc_pkg::PORT_CFG_OFS: rdata_next = port_cfg_reg;
                hpc_pkg::FIXED_OFS: rdata_next = fixed_reg;
                default: rdata_next = hpc_pkg::UNMAPPED_DATA;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            pwr_cfg_reg <= hpc_pkg::PWR_CFG_RST;
            port_cfg_reg <= hpc_pkg::PORT_CFG_RST;
            fixed_reg <= hpc_pkg::FIXED_RST;
            rdata_reg <= 8'h00;
        end
        else
        begin
            pwr_cfg_reg <= pwr_cfg_next;
            port_cfg_reg <= port_cfg_next;
            fixed_reg <= fixed_next;
            rdata_reg <= rdata_next;
        end
    end

    assign cfg_rdata_o = rdata_reg;

    // ------------------------------------------------------------
    // decoded configuration
    // ------------------------------------------------------------
    logic [3:0] fixed_ports;
    logic dyn_en;

    assign dyn_en = pwr_cfg_reg[hpc_pkg::DYN_BIT];
    assign fixed_ports = cfg_from_straps_i ? strap_ports(straps_s)
                                           : fixed_reg[hpc_pkg::FIXED_LSB +: 4];

    always_comb
    begin
        cfg_o.dyn_en = dyn_en;
        cfg_o.overcurrent_delay_sel = pwr_cfg_reg[hpc_pkg::OC_LSB +: 2];
        // the configuring party keeps the matching fixed-port bits
        cfg_o.compound = pwr_cfg_reg[hpc_pkg::COMPOUND_BIT]
                         | (cfg_from_straps_i & (|fixed_ports));
        cfg_o.port_remap_enable = port_cfg_reg[hpc_pkg::REMAP_BIT];
        cfg_o.string_en = port_cfg_reg[hpc_pkg::STRING_BIT];
        cfg_o.fixed_port_mask = fixed_ports;
    end

    // ------------------------------------------------------------
    // dynamic power switching
    // ------------------------------------------------------------
    hpc_pkg::hpc_pwr_state_t state_reg;
    hpc_pkg::hpc_pwr_state_t state_next;
    logic [hpc_pkg::DISC_CNT_W-1:0] disc_reg;
    logic [hpc_pkg::DISC_CNT_W-1:0] disc_next;
    logic seen_supply_reg;
    logic seen_supply_next;
    logic dyn_self_reg;
    logic dyn_self_next;
    logic supply_changed;

    // compared every cycle, so short supply dips are not missed
    assign supply_changed = supply_s != seen_supply_reg;

    always_comb
    begin
        state_next = state_reg;
        disc_next = disc_reg;
        seen_supply_next = supply_s;
        dyn_self_next = dyn_self_reg;
        unique case (state_reg)
            hpc_pkg::PWR_RUN:
            begin
                if (!dyn_en)
                begin
                    dyn_self_next = supply_s;
                end
                else if (supply_changed)
                begin
                    state_next = hpc_pkg::PWR_DROP;
                    disc_next = '0;
                end
            end
            hpc_pkg::PWR_DROP:
            begin
                // a further change restarts the quiet time
                if (supply_changed)
                begin
                    disc_next = '0;
                end
                else if (disc_reg >= hpc_pkg::DISC_CNT_W'(hpc_pkg::DISC_CYC - 1))
                begin
                    state_next = hpc_pkg::PWR_RUN;
                    dyn_self_next = supply_s;
                end
                else
                begin
                    disc_next = disc_reg + 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            state_reg <= hpc_pkg::PWR_RUN;
            disc_reg <= '0;
            seen_supply_reg <= 1'b0;
            dyn_self_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            disc_reg <= disc_next;
            seen_supply_reg <= seen_supply_next;
            dyn_self_reg <= dyn_self_next;
        end
    end

    assign upstream_attach_o = state_reg == hpc_pkg::PWR_RUN;
    assign downstream_power_en_o = state_reg == hpc_pkg::PWR_RUN;
    assign self_powered_o = dyn_en ? dyn_self_reg : static_self_powered_i;

    // ------------------------------------------------------------
    // over-current timer
    // ------------------------------------------------------------
    hpc_overcurrent_delay_sel #(
        .CNT0(OC_CNT0),
        .CNT1(OC_CNT1),
        .CNT2(OC_CNT2),
        .CNT3(OC_CNT3)
    ) u_overcurrent_delay_sel (
        .ref_clk_i(ref_clk_i),
        .arst_n_i(arst_n_i),
        .sel_i(pwr_cfg_reg[hpc_pkg::OC_LSB +: 2]),
        .oc_i(oc_s & downstream_power_en_o),
        .fault_o(overcurrent_fault_o)
    );

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    drop_on_change_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        dyn_en && upstream_attach_o && supply_changed |=> !upstream_attach_o && !downstream_power_en_o)
        else $error("supply change did not drop the links");

    drop_hold_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        $fell(upstream_attach_o) |-> !upstream_attach_o [*8])
        else $error("links came back too early");

    reattach_mode_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        $rose(upstream_attach_o) && dyn_en |-> self_powered_o == $past(supply_s))
        else $error("re-attached with wrong power mode");

    no_switch_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        !dyn_en && upstream_attach_o |=> upstream_attach_o)
        else $error("links dropped with dynamic switching off");

    static_mode_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        dyn_en && $stable(dyn_self_reg) |-> $stable(self_powered_o) || $changed(dyn_en))
        else $error("static power bit leaked into dynamic mode");

    strap_compound_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        cfg_from_straps_i && straps_s != 2'h0 |-> cfg_o.compound && cfg_o.fixed_port_mask[0])
        else $error("strap fixed port without compound report");

    reserved_zero_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (pwr_cfg_reg & ~hpc_pkg::PWR_CFG_MASK) == 8'h00
        && (port_cfg_reg & ~hpc_pkg::PORT_CFG_MASK) == 8'h00
        && (fixed_reg & ~hpc_pkg::FIXED_MASK) == 8'h00)
        else $error("reserved bit set");

    port_cfg_write_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        cfg_wr_i && cfg_addr_i == hpc_pkg::PORT_CFG_OFS
        |=> cfg_o.port_remap_enable == $past(cfg_wdata_i[3]) && cfg_o.string_en == $past(cfg_wdata_i[0]))
        else $error("port numbering write not applied");

endmodule : hpc_config_bank

// ==== verilog/hpc_overcurrent_delay_sel.sv ====
// over-current qualification timer with selectable delay
`timescale 1ns/10ps
module hpc_overcurrent_delay_sel #(
    parameter int CNT0 = hpc_pkg::OC_DLY0_CYC,
    parameter int CNT1 = hpc_pkg::OC_DLY1_CYC,
    parameter int CNT2 = hpc_pkg::OC_DLY2_CYC,
    parameter int CNT3 = hpc_pkg::OC_DLY3_CYC
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    // control
    input wire logic [1:0] sel_i,
    input wire logic oc_i,
    // result
    output logic fault_o
);

    logic [hpc_pkg::OC_CNT_W-1:0] cnt_reg;
    logic [hpc_pkg::OC_CNT_W-1:0] cnt_next;
    logic [hpc_pkg::OC_CNT_W-1:0] limit;
    logic fault_reg;
    logic fault_next;

    always_comb
    begin
        unique case (sel_i)
            2'h0: limit = hpc_pkg::OC_CNT_W'(CNT0);
            2'h1: limit = hpc_pkg::OC_CNT_W'(CNT1);
            2'h2: limit = hpc_pkg::OC_CNT_W'(CNT2);
            2'h3: limit = hpc_pkg::OC_CNT_W'(CNT3);
        endcase
        cnt_next = cnt_reg;
        fault_next = fault_reg;
        if (!oc_i)
        begin
            cnt_next = '0;
            fault_next = 1'b0;
        end
        else if (cnt_reg >= limit)
        begin
            fault_next = 1'b1;
        end
        else
        begin
            cnt_next = cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            cnt_reg <= '0;
            fault_reg <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            fault_reg <= fault_next;
        end
    end

    assign fault_o = fault_reg;

    oc_fault_late_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        $rose(fault_o) |-> $past(cnt_reg) >= $past(limit) && $past(oc_i))
        else $error("over-current fault raised before the selected delay");

    oc_fault_clear_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        !oc_i |=> !fault_o)
        else $error("over-current fault kept after the condition went away");

endmodule : hpc_overcurrent_delay_sel

// ==== verilog/hpc_pkg.sv ====
// package for the hub power and port configuration bank
package hpc_pkg;

    // ------------------------------------------------------------
    // register offsets and layout
    // ------------------------------------------------------------
    localparam logic [7:0] PWR_CFG_OFS = 8'h07;
    localparam logic [7:0] PORT_CFG_OFS = 8'h08;
    localparam logic [7:0] FIXED_OFS = 8'h09;

    localparam int DYN_BIT = 7;
    localparam int OC_LSB = 4;
    localparam int COMPOUND_BIT = 3;
    localparam int REMAP_BIT = 3;
    localparam int STRING_BIT = 0;
    localparam int FIXED_LSB = 1;

    // writable bits; everything else reads as zero
    localparam logic [7:0] PWR_CFG_MASK = 8'hB8;
    localparam logic [7:0] PORT_CFG_MASK = 8'h09;
    localparam logic [7:0] FIXED_MASK = 8'h1E;

    localparam logic [7:0] PWR_CFG_RST = 8'h00;
    localparam logic [7:0] PORT_CFG_RST = 8'h00;
    localparam logic [7:0] FIXED_RST = 8'h00;
    localparam logic [7:0] UNMAPPED_DATA = 8'h00;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int OC_DLY0_NS = 100000;
    localparam int OC_DLY1_NS = 4000000;
    localparam int OC_DLY2_NS = 8000000;
    localparam int OC_DLY3_NS = 16000000;
    localparam int OC_DLY0_CYC = OC_DLY0_NS / CLK_PERIOD_NS;
    localparam int OC_DLY1_CYC = OC_DLY1_NS / CLK_PERIOD_NS;
    localparam int OC_DLY2_CYC = OC_DLY2_NS / CLK_PERIOD_NS;
    localparam int OC_DLY3_CYC = OC_DLY3_NS / CLK_PERIOD_NS;
    localparam int OC_CNT_W = 24;

    // time the links stay dropped after a supply change
    localparam int DISC_TIME_NS = 10000;
    localparam int DISC_CYC = (DISC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DISC_CNT_W = 16;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [0:0] {PWR_RUN, PWR_DROP} hpc_pwr_state_t;

    typedef struct packed {
        logic dyn_en;
        logic [1:0] overcurrent_delay_sel;
        logic compound;
        logic port_remap_enable;
        logic string_en;
        logic [3:0] fixed_port_mask;
    } hpc_cfg_t;

endpackage : hpc_pkg
